// file: rtl/efad_datapath.sv
// Expanded format ALU datapath: register file, work register, operand mux, routing
module efad_datapath
  import efad_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic instrValid,
  input wire logic [ADDR_W-1:0] aAddr,
  input wire logic [ADDR_W-1:0] bAddr,
  input wire logic [SEL_W-1:0] operandPairSelect,
  input wire logic [SEL_W-1:0] resultRoutingSelect,
  input wire logic [SEL_W-1:0] operationSelect,
  input wire logic [FILL_W-1:0] shiftFillControl,
  input wire logic carryIn,
  input wire logic [DATA_W-1:0] dataBusIn,
  input wire logic busDriverSelect,
  output logic [DATA_W-1:0] yOut,
  output logic yValid,
  output logic [DATA_W-1:0] busOut,
  output logic busDriveValid,
  output logic [DATA_W-1:0] workRegOut,
  output logic carryFlag,
  output logic zeroFlag,
  output logic signFlag,
  output logic overflowFlag,
  output logic shiftOutBit
);

  logic [DATA_W-1:0] regFile_reg [REG_COUNT];
  logic [DATA_W-1:0] workReg_reg;
  logic [DATA_W-1:0] yOut_reg;
  logic [DATA_W-1:0] yOut_next;
  logic yValid_reg;
  logic [DATA_W-1:0] busOut_reg;
  logic busDriveValid_reg;
  logic carryFlag_reg;
  logic zeroFlag_reg;
  logic signFlag_reg;
  logic overflowFlag_reg;
  logic shiftOutBit_reg;
  logic shiftOutBit_next;

  logic [DATA_W-1:0] portA;
  logic [DATA_W-1:0] portB;
  logic [DATA_W-1:0] rOperand;
  logic [DATA_W-1:0] sOperand;
  logic [DATA_W-1:0] fResult;
  logic aluCarry;
  logic aluOverflow;

  efad_pair_t pairCode;
  efad_route_t routeCode;

  logic [DATA_W-1:0] regWrite_next;
  logic regWriteEn;
  logic [DATA_W-1:0] work_next;
  logic workWriteEn;
  logic rightFill;
  logic leftFill;
  logic [2*DATA_W-1:0] pairWord;

  // Independent read ports over one storage array; reads see pre-edge values
  always_comb begin
    portA = regFile_reg[aAddr];
    portB = regFile_reg[bAddr];
  end

  // Codes come straight from the decoder, three bits each
  always_comb begin
    pairCode = efad_pair_t'(operandPairSelect);
    routeCode = efad_route_t'(resultRoutingSelect);
  end

  // Operand mux: one code selects both R and S together
  // Zero never appears on the S side except in the bus-zero pair
  always_comb begin
    rOperand = WORD_ZERO;
    sOperand = WORD_ZERO;
    case (pairCode)
      PAIR_A_WORK: begin
        rOperand = portA;
        sOperand = workReg_reg;
      end
      PAIR_A_B: begin
        rOperand = portA;
        sOperand = portB;
      end
      PAIR_ZERO_WORK: begin
        rOperand = WORD_ZERO;
        sOperand = workReg_reg;
      end
      PAIR_ZERO_B: begin
        rOperand = WORD_ZERO;
        sOperand = portB;
      end
      PAIR_ZERO_A: begin
        rOperand = WORD_ZERO;
        sOperand = portA;
      end
      PAIR_BUS_A: begin
        rOperand = dataBusIn;
        sOperand = portA;
      end
      PAIR_BUS_WORK: begin
        rOperand = dataBusIn;
        sOperand = workReg_reg;
      end
      PAIR_BUS_ZERO: begin
        rOperand = dataBusIn;
        sOperand = WORD_ZERO;
      end
      default: begin
        rOperand = WORD_ZERO;
        sOperand = WORD_ZERO;
      end
    endcase
  end

  efad_function_unit u_function_unit (
    .rOperand(rOperand),
    .sOperand(sOperand),
    .carryIn(carryIn),
    .opCode(operationSelect),
    .fResult(fResult),
    .carryOut(aluCarry),
    .overflow(aluOverflow)
  );

  // Fill bits for the vacated end of a shift
  always_comb begin
    case (shiftFillControl)
      FILL_ZEROS: begin
        rightFill = 1'b0;
        leftFill = 1'b0;
      end
      FILL_ONES: begin
        rightFill = 1'b1;
        leftFill = 1'b1;
      end
      FILL_ROTATE: begin
        rightFill = (routeCode == ROUTE_DBL_RIGHT) ? workReg_reg[0] : fResult[0];
        leftFill = fResult[DATA_W-1];
      end
      FILL_SIGN: begin
        // Sign fill only means something going right; left gets zeros
        rightFill = fResult[DATA_W-1];
        leftFill = 1'b0;
      end
      default: begin
        rightFill = 1'b0;
        leftFill = 1'b0;
      end
    endcase
  end

  // Result and work register chained as one double word for double shifts
  always_comb begin
    pairWord = {fResult, workReg_reg};
  end

  // Destination routing: only work register, Y, the B entry and the shift-out bit can change
  always_comb begin
    regWrite_next = fResult;
    regWriteEn = 1'b0;
    work_next = workReg_reg;
    workWriteEn = 1'b0;
    yOut_next = fResult;
    shiftOutBit_next = shiftOutBit_reg;
    case (routeCode)
      ROUTE_WORK: begin
        work_next = fResult;
        workWriteEn = 1'b1;
        yOut_next = fResult;
      end
      ROUTE_NOLOAD: begin
        yOut_next = fResult;
      end
      ROUTE_AOUT: begin
        regWrite_next = fResult;
        regWriteEn = 1'b1;
        yOut_next = portA;
      end
      ROUTE_RESULT: begin
        regWrite_next = fResult;
        regWriteEn = 1'b1;
        yOut_next = fResult;
      end
      ROUTE_DBL_RIGHT: begin
        regWrite_next = {rightFill, pairWord[2*DATA_W-1:DATA_W+1]};
        work_next = pairWord[DATA_W:1];
        regWriteEn = 1'b1;
        workWriteEn = 1'b1;
        yOut_next = fResult;
        shiftOutBit_next = workReg_reg[0];
      end
      ROUTE_SGL_RIGHT: begin
        // Y shows the unshifted result, as the worked example does
        regWrite_next = {rightFill, fResult[DATA_W-1:1]};
        regWriteEn = 1'b1;
        yOut_next = fResult;
        shiftOutBit_next = fResult[0];
      end
      ROUTE_DBL_LEFT: begin
        regWrite_next = pairWord[2*DATA_W-2:DATA_W-1];
        work_next = {workReg_reg[DATA_W-2:0], leftFill};
        regWriteEn = 1'b1;
        workWriteEn = 1'b1;
        yOut_next = fResult;
        shiftOutBit_next = fResult[DATA_W-1];
      end
      ROUTE_SGL_LEFT: begin
        regWrite_next = {fResult[DATA_W-2:0], leftFill};
        regWriteEn = 1'b1;
        yOut_next = fResult;
        shiftOutBit_next = fResult[DATA_W-1];
      end
      default: begin
        regWriteEn = 1'b0;
        workWriteEn = 1'b0;
      end
    endcase
  end

  // Register file: one write port at the B address, taken at the clock edge
  for (genvar i = 0; i < REG_COUNT; i++) begin : g_entry
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        regFile_reg[i] <= WORD_RESET;
      end else if (instrValid && regWriteEn && (bAddr == ADDR_W'(i))) begin
        regFile_reg[i] <= regWrite_next;
      end
    end
  end

  // Work register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      workReg_reg <= WORD_RESET;
    end else if (instrValid && workWriteEn) begin
      workReg_reg <= work_next;
    end
  end

  // Y output captured each valid instruction; it holds between instructions
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      yOut_reg <= WORD_RESET;
      yValid_reg <= 1'b0;
    end else begin
      yValid_reg <= instrValid;
      if (instrValid) begin
        yOut_reg <= yOut_next;
      end
    end
  end

  // Internal bus drive; the bus itself is muxed outside, this is the ALU leg
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busOut_reg <= WORD_RESET;
      busDriveValid_reg <= 1'b0;
    end else begin
      busDriveValid_reg <= instrValid & busDriverSelect;
      if (instrValid && busDriverSelect) begin
        busOut_reg <= yOut_next;
      end
    end
  end

  // Status flags follow the unshifted function result
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      carryFlag_reg <= 1'b0;
      zeroFlag_reg <= 1'b0;
      signFlag_reg <= 1'b0;
      overflowFlag_reg <= 1'b0;
    end else if (instrValid) begin
      carryFlag_reg <= aluCarry;
      zeroFlag_reg <= (fResult == WORD_ZERO);
      signFlag_reg <= fResult[DATA_W-1];
      overflowFlag_reg <= aluOverflow;
    end
  end

  // Bit lost off the end of the last shift
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      shiftOutBit_reg <= 1'b0;
    end else if (instrValid) begin
      shiftOutBit_reg <= shiftOutBit_next;
    end
  end

  always_comb begin
    yOut = yOut_reg;
    yValid = yValid_reg;
    busOut = busOut_reg;
    busDriveValid = busDriveValid_reg;
    workRegOut = workReg_reg;
    carryFlag = carryFlag_reg;
    zeroFlag = zeroFlag_reg;
    signFlag = signFlag_reg;
    overflowFlag = overflowFlag_reg;
    shiftOutBit = shiftOutBit_reg;
  end

endmodule // efad_datapath

// file: rtl/efad_pkg.sv
// Shared constants and types for the expanded format ALU datapath
package efad_pkg;

  localparam int DATA_W = 16;
  localparam int REG_COUNT = 16;
  localparam int ADDR_W = 4;
  localparam int SEL_W = 3;
  localparam int FILL_W = 2;

  localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] WORD_RESET = 16'h0000;

  // Operand pair codes, R source first
  typedef enum logic [SEL_W-1:0] {
    PAIR_A_WORK = 3'h0,
    PAIR_A_B = 3'h1,
    PAIR_ZERO_WORK = 3'h2,
    PAIR_ZERO_B = 3'h3,
    PAIR_ZERO_A = 3'h4,
    PAIR_BUS_A = 3'h5,
    PAIR_BUS_WORK = 3'h6,
    PAIR_BUS_ZERO = 3'h7
  } efad_pair_t;

  // Result routing codes
  typedef enum logic [SEL_W-1:0] {
    ROUTE_WORK = 3'h0,
    ROUTE_NOLOAD = 3'h1,
    ROUTE_AOUT = 3'h2,
    ROUTE_RESULT = 3'h3,
    ROUTE_DBL_RIGHT = 3'h4,
    ROUTE_SGL_RIGHT = 3'h5,
    ROUTE_DBL_LEFT = 3'h6,
    ROUTE_SGL_LEFT = 3'h7
  } efad_route_t;

  // Operation codes
  typedef enum logic [SEL_W-1:0] {
    OP_ADD = 3'h0,
    OP_SUB = 3'h1,
    OP_SUBREV = 3'h2,
    OP_OR = 3'h3,
    OP_AND = 3'h4,
    OP_NOTR_AND = 3'h5,
    OP_XOR = 3'h6,
    OP_NOTR_XOR = 3'h7
  } efad_op_t;

  // Shift fill codes
  localparam logic [FILL_W-1:0] FILL_ZEROS = 2'h0;
  localparam logic [FILL_W-1:0] FILL_ONES = 2'h1;
  localparam logic [FILL_W-1:0] FILL_ROTATE = 2'h2;
  localparam logic [FILL_W-1:0] FILL_SIGN = 2'h3;

endpackage

// file: rtl/efad_function_unit.sv
// Combinational eight-function ALU core
module efad_function_unit
  import efad_pkg::*;
(
  input wire logic [DATA_W-1:0] rOperand,
  input wire logic [DATA_W-1:0] sOperand,
  input wire logic carryIn,
  input wire logic [SEL_W-1:0] opCode,
  output logic [DATA_W-1:0] fResult,
  output logic carryOut,
  output logic overflow
);

  logic [DATA_W:0] sum;
  logic [DATA_W-1:0] addL;
  logic [DATA_W-1:0] addR;
  logic arith;

  // Subtraction is add of the inverse, so NOT C as borrow equals C as carry
  always_comb begin
    addL = rOperand;
    addR = sOperand;
    arith = 1'b1;
    fResult = WORD_ZERO;
    case (efad_op_t'(opCode))
      OP_ADD: begin
        addL = rOperand;
        addR = sOperand;
      end
      OP_SUB: begin
        addL = rOperand;
        addR = ~sOperand;
      end
      OP_SUBREV: begin
        addL = sOperand;
        addR = ~rOperand;
      end
      OP_OR: begin
        arith = 1'b0;
        fResult = rOperand | sOperand;
      end
      OP_AND: begin
        arith = 1'b0;
        fResult = rOperand & sOperand;
      end
      OP_NOTR_AND: begin
        arith = 1'b0;
        fResult = ~rOperand & sOperand;
      end
      OP_XOR: begin
        arith = 1'b0;
        fResult = rOperand ^ sOperand;
      end
      OP_NOTR_XOR: begin
        arith = 1'b0;
        fResult = ~rOperand ^ sOperand;
      end
      default: begin
        arith = 1'b0;
        fResult = WORD_ZERO;
      end
    endcase
    sum = {1'b0, addL} + {1'b0, addR} + {{DATA_W{1'b0}}, carryIn};
    if (arith) begin
      fResult = sum[DATA_W-1:0];
    end
  end

  always_comb begin
    carryOut = arith & sum[DATA_W];
    overflow = arith & (addL[DATA_W-1] == addR[DATA_W-1]) & (sum[DATA_W-1] != addL[DATA_W-1]);
  end

endmodule // efad_function_unit

// file: testbench/efad_datapath_chk.sv
// Port-level assertions for the expanded format ALU datapath
module efad_datapath_chk
  import efad_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic instrValid,
  input wire logic [SEL_W-1:0] operandPairSelect,
  input wire logic [SEL_W-1:0] resultRoutingSelect,
  input wire logic [SEL_W-1:0] operationSelect,
  input wire logic [DATA_W-1:0] dataBusIn,
  input wire logic busDriverSelect,
  input wire logic [DATA_W-1:0] yOut,
  input wire logic yValid,
  input wire logic [DATA_W-1:0] busOut,
  input wire logic busDriveValid,
  input wire logic [DATA_W-1:0] workRegOut
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_result_one_cycle: assert property (instrValid |=> yValid)
    else $error("yValid missing after instruction");
  chk_idle_quiet: assert property (!instrValid |=> !yValid && $stable(yOut) && $stable(workRegOut))
    else $error("idle cycle changed outputs");
  chk_bus_copy: assert property (instrValid && busDriverSelect |=> busDriveValid && busOut == yOut)
    else $error("bus not driven with Y");
  chk_work_load: assert property (instrValid && resultRoutingSelect == ROUTE_WORK |=> workRegOut == yOut)
    else $error("work register not loaded");
  chk_work_kept: assert property (instrValid && resultRoutingSelect inside {ROUTE_NOLOAD, ROUTE_AOUT,
    ROUTE_RESULT, ROUTE_SGL_RIGHT, ROUTE_SGL_LEFT} |=> $stable(workRegOut))
    else $error("work register written");
  chk_bus_pass: assert property (instrValid && operandPairSelect == PAIR_BUS_ZERO && operationSelect == OP_OR
    && resultRoutingSelect != ROUTE_AOUT |=> yOut == $past(dataBusIn))
    else $error("bus operand not passed");
  chk_zero_and: assert property (instrValid && operandPairSelect inside {PAIR_ZERO_WORK, PAIR_ZERO_B, PAIR_ZERO_A}
    && operationSelect == OP_AND && resultRoutingSelect != ROUTE_AOUT |=> yOut == WORD_ZERO)
    else $error("zero operand not zero");
  chk_dbl_right_work: assert property (instrValid && resultRoutingSelect == ROUTE_DBL_RIGHT
    |=> workRegOut[15] == yOut[0] && workRegOut[14:0] == $past(workRegOut) >> 1)
    else $error("work register right shift wrong");
  chk_dbl_left_work: assert property (instrValid && resultRoutingSelect == ROUTE_DBL_LEFT
    |=> {workRegOut[15:1], 1'h0} == $past(workRegOut) << 1)
    else $error("work register left shift wrong");
endmodule // efad_datapath_chk

bind efad_datapath efad_datapath_chk chk (.clk(clk), .sys_rst(sys_rst), .instrValid(instrValid),
  .operandPairSelect(operandPairSelect), .resultRoutingSelect(resultRoutingSelect),
  .operationSelect(operationSelect), .dataBusIn(dataBusIn), .busDriverSelect(busDriverSelect),
  .yOut(yOut), .yValid(yValid), .busOut(busOut), .busDriveValid(busDriveValid), .workRegOut(workRegOut));

// file: testbench/efad_bus_model.sv
// Data bus partner: loops driven Y back, else a fresh word each cycle
module efad_bus_model
  import efad_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic busDriveValid,
  input wire logic [DATA_W-1:0] busOut,
  output logic [DATA_W-1:0] dataBusIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven bus takes a fresh random word each cycle, so a stale sample shows up
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) dataBusIn <= WORD_ZERO;
    else dataBusIn <= busDriveValid ? busOut : DATA_W'($urandom);
  end
endmodule // efad_bus_model

// file: testbench/tb_top.sv
// Self-checking bench for the expanded format ALU datapath
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_top
  import efad_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, sys_rst = 1, instrValid = 0, carryIn = 0, busDriverSelect = 0, pend = 0;
  logic [3:0] aAddr = 0, bAddr = 0;
  logic [2:0] operandPairSelect = 0, resultRoutingSelect = 0, operationSelect = 0;
  logic [1:0] shiftFillControl = 0;
  logic [15:0] dataBusIn, yOut, busOut, workRegOut;
  logic yValid, busDriveValid, carryFlag, zeroFlag, signFlag, overflowFlag, shiftOutBit;
  logic [15:0] regs [16] = '{default: 16'h0000};
  logic [15:0] mq = 0, my = 0, mb = 0;
  logic mv = 0, mbv = 0, mc = 0, mz = 0, ms = 0, mo = 0, msb = 0;
  int failures = 0, compares = 0;

  always #12.5 clk = ~clk;

  efad_datapath dut (.clk(clk), .sys_rst(sys_rst), .instrValid(instrValid), .aAddr(aAddr), .bAddr(bAddr),
    .operandPairSelect(operandPairSelect), .resultRoutingSelect(resultRoutingSelect),
    .operationSelect(operationSelect), .shiftFillControl(shiftFillControl), .carryIn(carryIn),
    .dataBusIn(dataBusIn), .busDriverSelect(busDriverSelect), .yOut(yOut), .yValid(yValid), .busOut(busOut),
    .busDriveValid(busDriveValid), .workRegOut(workRegOut), .carryFlag(carryFlag), .zeroFlag(zeroFlag),
    .signFlag(signFlag), .overflowFlag(overflowFlag), .shiftOutBit(shiftOutBit));
  efad_bus_model bus (.clk(clk), .sys_rst(sys_rst), .busDriveValid(busDriveValid), .busOut(busOut),
    .dataBusIn(dataBusIn));

  // Reference step, run on the sampling edge before any update lands
  task automatic model_edge();
    logic [16:0] x;
    logic [15:0] r, s, f, ra, rb, al, ar;
    logic fl;
    mv = instrValid;
    mbv = instrValid & busDriverSelect;
    if (instrValid) begin
      ra = regs[aAddr];
      rb = regs[bAddr];
      case (operandPairSelect)
        3'h0: {r, s} = {ra, mq};
        3'h1: {r, s} = {ra, rb};
        3'h2: {r, s} = {16'h0000, mq};
        3'h3: {r, s} = {16'h0000, rb};
        3'h4: {r, s} = {16'h0000, ra};
        3'h5: {r, s} = {dataBusIn, ra};
        3'h6: {r, s} = {dataBusIn, mq};
        default: {r, s} = {dataBusIn, 16'h0000};
      endcase
      case (operationSelect)
        3'h0: x = {1'h0, r} + {1'h0, s} + {16'h0000, carryIn};
        3'h1: x = {1'h0, r} + {1'h0, ~s} + {16'h0000, carryIn};
        3'h2: x = {1'h0, s} + {1'h0, ~r} + {16'h0000, carryIn};
        3'h3: x = {1'h0, r | s};
        3'h4: x = {1'h0, r & s};
        3'h5: x = {1'h0, ~r & s};
        3'h6: x = {1'h0, r ^ s};
        default: x = {1'h0, ~r ^ s};
      endcase
      f = x[15:0];
      mc = x[16];
      mz = f == 16'h0000;
      my = f;
      ms = f[15];
      // Overflow only for the three adder functions, judged on the adder's own inputs
      al = operationSelect == 3'h2 ? s : r;
      ar = operationSelect == 3'h0 ? s : operationSelect == 3'h1 ? ~s : ~r;
      mo = operationSelect < 3'h3 && al[15] == ar[15] && f[15] != al[15];
      case (resultRoutingSelect)
        3'h4: msb = mq[0];
        3'h5: msb = f[0];
        3'h6, 3'h7: msb = f[15];
        default: ;
      endcase
      case (shiftFillControl)
        2'h1: fl = 1'h1;
        2'h2: fl = resultRoutingSelect == 3'h4 ? mq[0] : resultRoutingSelect == 3'h5 ? f[0] : f[15];
        2'h3: fl = resultRoutingSelect < 3'h6 ? f[15] : 1'h0;
        default: fl = 1'h0;
      endcase
      case (resultRoutingSelect)
        3'h0: mq = f;
        3'h2: regs[bAddr] = f;
        3'h3: regs[bAddr] = f;
        3'h4: regs[bAddr] = {fl, f[15:1]};
        3'h5: regs[bAddr] = {fl, f[15:1]};
        3'h6: regs[bAddr] = {f[14:0], mq[15]};
        3'h7: regs[bAddr] = {f[14:0], fl};
        default: ;
      endcase
      if (resultRoutingSelect == 3'h2) my = ra;
      if (resultRoutingSelect == 3'h4) mq = {f[0], mq[15:1]};
      if (resultRoutingSelect == 3'h6) mq = {mq[14:0], fl};
      if (busDriverSelect) mb = my;
    end
  endtask

  // Mode 0 idle, 1 given codes, 2 random; fields change only on the rising edge
  task automatic step(input int mode, input logic [8:0] code);
    logic [31:0] r;
    r = $urandom;
    if (mode == 1) r[12:4] = code;
    instrValid <= (mode == 1) || (mode == 2 && r[31:30] != 2'h0);
    {aAddr, bAddr, operandPairSelect, resultRoutingSelect, operationSelect, shiftFillControl, carryIn,
      busDriverSelect} <= r[20:0];
    @(posedge clk);
    model_edge();
    pend = 1;
  endtask

  always @(negedge clk) begin
    if (pend) begin
      pend = 0;
      `CHK("yOut", my, yOut)
      `CHK("yValid", mv, yValid)
      `CHK("workRegOut", mq, workRegOut)
      `CHK("busOut", mb, busOut)
      `CHK("busDriveValid", mbv, busDriveValid)
      `CHK("carryFlag", mc, carryFlag)
      `CHK("zeroFlag", mz, zeroFlag)
      `CHK("signFlag", ms, signFlag)
      `CHK("overflowFlag", mo, overflowFlag)
      `CHK("shiftOutBit", msb, shiftOutBit)
    end
  end

  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    void'($urandom(23478));
    repeat (12) @(posedge clk);
    sys_rst <= 1'h0;
    // Every operand, routing and operation code, back to back
    for (int i = 0; i < 512; i++) step(1, 9'(i));
    step(0, 9'h000);
    $display("test code_sweep done");
    // Mixed idle and busy cycles exercise holds and stale reads
    repeat (400) step(2, 9'h000);
    step(0, 9'h000);
    $display("test random_mix done");
    // Mid-run reset clears every output and register; work resumes at the first edge after
    @(posedge clk);
    sys_rst <= 1'h1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    foreach (regs[i]) regs[i] = 16'h0000;
    {mq, my, mb} = 48'h0;
    {mv, mbv, mc, mz, ms, mo, msb} = 7'h00;
    pend = 1;
    repeat (50) step(2, 9'h000);
    step(0, 9'h000);
    $display("test reset_restart done");
    @(posedge clk);
    close_out();
  end

  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    close_out();
  end
endmodule // tb_top
